// >>> include/bod_pkg.sv
//------------------------------------------------------------------------------
// Overview of operation
//------------------------------------------------------------------------------
// Overview of operation
// - Swap exchanges the operand's two nibbles
// - Destination bit: 0 to work, 1 to memory
// - Access bit: 0 access bank, 1 bank select
// - Extended mode, a=0, f<=95: pointer plus offset
// - Indexed add updates destination and five flags
// - Fill writes FFh at the effective address (pointer plus offset only in extended mode, a=0, f<=95)
// - One instruction cycle is four clock periods
//------------------------------------------------------------------------------
package bod_pkg;
    // Timing
    localparam int CLK_PERIOD_NS = 25;
    localparam int TCY_OSC_PERIODS = 4;
    localparam int TCY_NS = TCY_OSC_PERIODS * CLK_PERIOD_NS;
    localparam int TCY_CLKS = TCY_NS / CLK_PERIOD_NS;

    // Bus and memory
    localparam int ADDR_W = 8;
    localparam int MEM_AW = 12;
    localparam int MEM_WORDS = 4096;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Register offsets
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] INSTR_OFS = 8'h04;
    localparam logic [7:0] WORK_OFS = 8'h08;
    localparam logic [7:0] PTR_OFS = 8'h0C;
    localparam logic [7:0] BANK_OFS = 8'h10;
    localparam logic [7:0] STATUS_OFS = 8'h14;
    localparam logic [7:0] MEM_ADDR_OFS = 8'h18;
    localparam logic [7:0] MEM_DATA_OFS = 8'h1C;

    // Field positions
    localparam int CTRL_EXT_BIT = 0;
    localparam int ST_C = 0;
    localparam int ST_DC = 1;
    localparam int ST_Z = 2;
    localparam int ST_OV = 3;
    localparam int ST_N = 4;
    localparam int ST_ILL = 6;
    localparam int ST_BUSY = 7;
    localparam int FLAG_W = 5;

    // Reset values
    localparam logic CTRL_RST = 1'b0;
    localparam logic [15:0] INSTR_RST = 16'h0000;
    localparam logic [7:0] WORK_RST = 8'h00;
    localparam logic [11:0] PTR_RST = 12'h000;
    localparam logic [3:0] BANK_RST = 4'h0;
    localparam logic [4:0] FLAGS_RST = 5'h00;
    localparam logic [11:0] MEM_ADDR_RST = 12'h000;

    // Opcode patterns and addressing
    localparam logic [5:0] OPC_SWAP = 6'h0E;
    localparam logic [5:0] OPC_ADD = 6'h09;
    localparam logic [6:0] OPC_FILL = 7'h34;
    localparam logic [3:0] OPC_BSET = 4'h8;
    localparam logic [7:0] IDX_LIMIT = 8'h5F;
    localparam logic [3:0] ACC_HI_PAGE = 4'hF;
    localparam logic [3:0] ACC_LO_PAGE = 4'h0;
    localparam logic [7:0] FILL_VALUE = 8'hFF;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_DECODE = 3'b001,
        ST_READ = 3'b010,
        ST_PROC = 3'b011,
        ST_WRITE = 3'b100
    } bod_state_t;

    typedef enum logic [2:0] {
        OP_NONE = 3'b000,
        OP_SWAP = 3'b001,
        OP_ADD = 3'b010,
        OP_FILL = 3'b011,
        OP_BSET = 3'b100
    } bod_op_t;
endpackage : bod_pkg

// >>> hw/bod_alu.sv
`timescale 1ns/100ps
`default_nettype none
module bod_alu (
    input wire bod_pkg::bod_op_t op_i,
    input wire logic [7:0] opnd_i,
    input wire logic [7:0] work_i,
    input wire logic [2:0] bit_i,
    output logic [7:0] res_o,
    output logic [4:0] flags_o,
    output logic flags_we_o
);
    logic [8:0] sum;
    logic [4:0] low_sum;

    always_comb begin
        sum = {1'b0, work_i} + {1'b0, opnd_i};
        low_sum = {1'b0, work_i[3:0]} + {1'b0, opnd_i[3:0]};
        res_o = opnd_i;
        flags_o = '0;
        flags_we_o = 1'b0;
        case (op_i)
            bod_pkg::OP_SWAP: begin
                res_o = {opnd_i[3:0], opnd_i[7:4]};
            end
            bod_pkg::OP_ADD: begin
                res_o = sum[7:0];
                flags_we_o = 1'b1;
                flags_o[bod_pkg::ST_C] = sum[8];
                flags_o[bod_pkg::ST_DC] = low_sum[4];
                flags_o[bod_pkg::ST_Z] = (sum[7:0] == 8'h00);
                flags_o[bod_pkg::ST_OV] = (work_i[7] == opnd_i[7]) && (sum[7] != work_i[7]);
                flags_o[bod_pkg::ST_N] = sum[7];
            end
            bod_pkg::OP_FILL: begin
                res_o = bod_pkg::FILL_VALUE;
            end
            bod_pkg::OP_BSET: begin
                res_o = opnd_i | (8'h01 << bit_i);
            end
            default: begin
                res_o = opnd_i;
            end
        endcase
    end
endmodule : bod_alu
`default_nettype wire

// >>> hw/bod_core.sv
`timescale 1ns/100ps
`default_nettype none
module bod_core (
    input wire logic CLK_I,
    input wire logic RST_N_I,
    input wire logic [7:0] S_AXI_AWADDR_I,
    input wire logic S_AXI_AWVALID_I,
    output logic S_AXI_AWREADY_O,
    input wire logic [31:0] S_AXI_WDATA_I,
    input wire logic [3:0] S_AXI_WSTRB_I,
    input wire logic S_AXI_WVALID_I,
    output logic S_AXI_WREADY_O,
    output logic [1:0] S_AXI_BRESP_O,
    output logic S_AXI_BVALID_O,
    input wire logic S_AXI_BREADY_I,
    input wire logic [7:0] S_AXI_ARADDR_I,
    input wire logic S_AXI_ARVALID_I,
    output logic S_AXI_ARREADY_O,
    output logic [31:0] S_AXI_RDATA_O,
    output logic [1:0] S_AXI_RRESP_O,
    output logic S_AXI_RVALID_O,
    input wire logic S_AXI_RREADY_I
);
    //--------------------------------------------------------------------------
    // Declarations
    //--------------------------------------------------------------------------
    logic [7:0] mem [0:bod_pkg::MEM_WORDS-1];
    logic ext_en_q;
    logic [15:0] instr_q;
    logic [7:0] work_q;
    logic [11:0] ptr_q;
    logic [3:0] bank_q;
    logic [4:0] flags_q;
    logic ill_q;
    logic [11:0] mem_addr_q;
    bod_pkg::bod_state_t state_q;
    bod_pkg::bod_op_t op_q;
    bod_pkg::bod_op_t op_d;
    logic [11:0] ea_q;
    logic [11:0] ea_d;
    logic dest_w_q;
    logic dest_mem_q;
    logic [7:0] opnd_q;
    logic [7:0] res_q;
    logic [4:0] nflags_q;
    logic flags_we_q;
    logic [7:0] alu_res;
    logic [4:0] alu_flags;
    logic alu_flags_we;
    logic busy;
    logic start;
    logic aw_got_q;
    logic w_got_q;
    logic [7:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;
    logic sw_wr;
    logic wr_hit;
    logic [31:0] wr_old;
    logic [31:0] wr_val;
    logic [31:0] rd_val;
    logic rd_hit;
    logic mem_we;
    logic [11:0] mem_wa;
    logic [7:0] mem_wd;
    logic [2:0] busy_cnt_q;

    function automatic logic [31:0] bod_merge(input logic [31:0] old, input logic [31:0] nw,
                                               input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction : bod_merge

    //--------------------------------------------------------------------------
    // AXI4-Lite write channel
    //--------------------------------------------------------------------------
    assign S_AXI_AWREADY_O = !aw_got_q && !bvalid_q;
    assign S_AXI_WREADY_O = !w_got_q && !bvalid_q;
    assign S_AXI_BVALID_O = bvalid_q;
    assign S_AXI_BRESP_O = bresp_q;
    assign busy = (state_q != bod_pkg::ST_IDLE);
    assign sw_wr = aw_got_q && w_got_q && !bvalid_q && !busy;

    always_ff @(posedge CLK_I) begin
        if (!RST_N_I) begin
            aw_got_q <= 1'b0;
            w_got_q <= 1'b0;
            awaddr_q <= 8'h00;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
            bvalid_q <= 1'b0;
            bresp_q <= bod_pkg::RESP_OKAY;
        end else begin
            if (S_AXI_AWVALID_I && S_AXI_AWREADY_O) begin
                aw_got_q <= 1'b1;
                awaddr_q <= S_AXI_AWADDR_I;
            end
            if (S_AXI_WVALID_I && S_AXI_WREADY_O) begin
                w_got_q <= 1'b1;
                wdata_q <= S_AXI_WDATA_I;
                wstrb_q <= S_AXI_WSTRB_I;
            end
            if (sw_wr) begin
                aw_got_q <= 1'b0;
                w_got_q <= 1'b0;
                bvalid_q <= 1'b1;
                bresp_q <= wr_hit ? bod_pkg::RESP_OKAY : bod_pkg::RESP_SLVERR;
            end else if (bvalid_q && S_AXI_BREADY_I) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    always_comb begin
        wr_hit = 1'b1;
        wr_old = 32'h0000_0000;
        if (awaddr_q == bod_pkg::CTRL_OFS) begin
            wr_old[bod_pkg::CTRL_EXT_BIT] = ext_en_q;
        end else if (awaddr_q == bod_pkg::INSTR_OFS) begin
            wr_old[15:0] = instr_q;
        end else if (awaddr_q == bod_pkg::WORK_OFS) begin
            wr_old[7:0] = work_q;
        end else if (awaddr_q == bod_pkg::PTR_OFS) begin
            wr_old[11:0] = ptr_q;
        end else if (awaddr_q == bod_pkg::BANK_OFS) begin
            wr_old[3:0] = bank_q;
        end else if (awaddr_q == bod_pkg::STATUS_OFS) begin
            wr_old[4:0] = flags_q;
            wr_old[bod_pkg::ST_ILL] = ill_q;
        end else if (awaddr_q == bod_pkg::MEM_ADDR_OFS) begin
            wr_old[11:0] = mem_addr_q;
        end else if (awaddr_q == bod_pkg::MEM_DATA_OFS) begin
            wr_old[7:0] = mem[mem_addr_q];
        end else begin
            wr_hit = 1'b0;
        end
    end

    assign wr_val = bod_merge(wr_old, wdata_q, wstrb_q);
    assign start = sw_wr && (awaddr_q == bod_pkg::INSTR_OFS);

    //--------------------------------------------------------------------------
    // Software registers
    //--------------------------------------------------------------------------
    always_ff @(posedge CLK_I) begin
        if (!RST_N_I) begin
            ext_en_q <= bod_pkg::CTRL_RST;
            instr_q <= bod_pkg::INSTR_RST;
            ptr_q <= bod_pkg::PTR_RST;
            bank_q <= bod_pkg::BANK_RST;
            mem_addr_q <= bod_pkg::MEM_ADDR_RST;
        end else if (sw_wr) begin
            if (awaddr_q == bod_pkg::CTRL_OFS) begin
                ext_en_q <= wr_val[bod_pkg::CTRL_EXT_BIT];
            end else if (awaddr_q == bod_pkg::INSTR_OFS) begin
                instr_q <= wr_val[15:0];
            end else if (awaddr_q == bod_pkg::PTR_OFS) begin
                ptr_q <= wr_val[11:0];
            end else if (awaddr_q == bod_pkg::BANK_OFS) begin
                bank_q <= wr_val[3:0];
            end else if (awaddr_q == bod_pkg::MEM_ADDR_OFS) begin
                mem_addr_q <= wr_val[11:0];
            end
        end
    end

    // Work register: software or instruction result
    always_ff @(posedge CLK_I) begin
        if (!RST_N_I) begin
            work_q <= bod_pkg::WORK_RST;
        end else if (state_q == bod_pkg::ST_WRITE && dest_w_q) begin
            work_q <= res_q;
        end else if (sw_wr && awaddr_q == bod_pkg::WORK_OFS) begin
            work_q <= wr_val[7:0];
        end
    end

    // Status flags and sticky illegal-opcode flag
    always_ff @(posedge CLK_I) begin
        if (!RST_N_I) begin
            flags_q <= bod_pkg::FLAGS_RST;
            ill_q <= 1'b0;
        end else if (sw_wr && awaddr_q == bod_pkg::STATUS_OFS) begin
            flags_q <= wr_val[4:0];
            ill_q <= wr_val[bod_pkg::ST_ILL];
        end else begin
            if (state_q == bod_pkg::ST_WRITE && flags_we_q) begin
                flags_q <= nflags_q;
            end
            if (state_q == bod_pkg::ST_DECODE && op_d == bod_pkg::OP_NONE) begin
                ill_q <= 1'b1;
            end
        end
    end

    //--------------------------------------------------------------------------
    // AXI4-Lite read channel
    //--------------------------------------------------------------------------
    assign S_AXI_ARREADY_O = !rvalid_q;
    assign S_AXI_RVALID_O = rvalid_q;
    assign S_AXI_RDATA_O = rdata_q;
    assign S_AXI_RRESP_O = rresp_q;

    always_comb begin
        rd_hit = 1'b1;
        rd_val = 32'h0000_0000;
        if (S_AXI_ARADDR_I == bod_pkg::CTRL_OFS) begin
            rd_val[bod_pkg::CTRL_EXT_BIT] = ext_en_q;
        end else if (S_AXI_ARADDR_I == bod_pkg::INSTR_OFS) begin
            rd_val[15:0] = instr_q;
        end else if (S_AXI_ARADDR_I == bod_pkg::WORK_OFS) begin
            rd_val[7:0] = work_q;
        end else if (S_AXI_ARADDR_I == bod_pkg::PTR_OFS) begin
            rd_val[11:0] = ptr_q;
        end else if (S_AXI_ARADDR_I == bod_pkg::BANK_OFS) begin
            rd_val[3:0] = bank_q;
        end else if (S_AXI_ARADDR_I == bod_pkg::STATUS_OFS) begin
            rd_val[4:0] = flags_q;
            rd_val[bod_pkg::ST_ILL] = ill_q;
            rd_val[bod_pkg::ST_BUSY] = busy;
        end else if (S_AXI_ARADDR_I == bod_pkg::MEM_ADDR_OFS) begin
            rd_val[11:0] = mem_addr_q;
        end else if (S_AXI_ARADDR_I == bod_pkg::MEM_DATA_OFS) begin
            rd_val[7:0] = mem[mem_addr_q];
        end else begin
            rd_hit = 1'b0;
        end
    end

    always_ff @(posedge CLK_I) begin
        if (!RST_N_I) begin
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            rresp_q <= bod_pkg::RESP_OKAY;
        end else if (S_AXI_ARVALID_I && S_AXI_ARREADY_O) begin
            rvalid_q <= 1'b1;
            rdata_q <= rd_val;
            rresp_q <= rd_hit ? bod_pkg::RESP_OKAY : bod_pkg::RESP_SLVERR;
        end else if (rvalid_q && S_AXI_RREADY_I) begin
            rvalid_q <= 1'b0;
        end
    end

    //--------------------------------------------------------------------------
    // Decode and operand addressing
    //--------------------------------------------------------------------------
    always_comb begin
        op_d = bod_pkg::OP_NONE;
        if (instr_q[15:10] == bod_pkg::OPC_SWAP) begin
            op_d = bod_pkg::OP_SWAP;
        end else if (instr_q[15:10] == bod_pkg::OPC_ADD) begin
            op_d = bod_pkg::OP_ADD;
        end else if (instr_q[15:9] == bod_pkg::OPC_FILL) begin
            op_d = bod_pkg::OP_FILL;
        end else if (instr_q[15:12] == bod_pkg::OPC_BSET) begin
            op_d = bod_pkg::OP_BSET;
        end
    end

    always_comb begin
        if (instr_q[8]) begin
            ea_d = {bank_q, instr_q[7:0]};
        end else if (ext_en_q && instr_q[7:0] <= bod_pkg::IDX_LIMIT) begin
            ea_d = ptr_q + {4'h0, instr_q[7:0]};
        end else if (instr_q[7:0] <= bod_pkg::IDX_LIMIT) begin
            ea_d = {bod_pkg::ACC_LO_PAGE, instr_q[7:0]};
        end else begin
            ea_d = {bod_pkg::ACC_HI_PAGE, instr_q[7:0]};
        end
    end

    //--------------------------------------------------------------------------
    // Four-phase instruction cycle
    //--------------------------------------------------------------------------
    always_ff @(posedge CLK_I) begin
        if (!RST_N_I) begin
            state_q <= bod_pkg::ST_IDLE;
        end else begin
            case (state_q)
                bod_pkg::ST_IDLE: state_q <= start ? bod_pkg::ST_DECODE : bod_pkg::ST_IDLE;
                bod_pkg::ST_DECODE: state_q <= bod_pkg::ST_READ;
                bod_pkg::ST_READ: state_q <= bod_pkg::ST_PROC;
                bod_pkg::ST_PROC: state_q <= bod_pkg::ST_WRITE;
                default: state_q <= bod_pkg::ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge CLK_I) begin
        if (!RST_N_I) begin
            op_q <= bod_pkg::OP_NONE;
            ea_q <= 12'h000;
            dest_w_q <= 1'b0;
            dest_mem_q <= 1'b0;
            opnd_q <= 8'h00;
            res_q <= 8'h00;
            nflags_q <= 5'h00;
            flags_we_q <= 1'b0;
        end else begin
            if (state_q == bod_pkg::ST_DECODE) begin
                op_q <= op_d;
                ea_q <= ea_d;
                dest_w_q <= (op_d == bod_pkg::OP_SWAP || op_d == bod_pkg::OP_ADD) && !instr_q[9];
                dest_mem_q <= ((op_d == bod_pkg::OP_SWAP || op_d == bod_pkg::OP_ADD) && instr_q[9])
                              || op_d == bod_pkg::OP_FILL || op_d == bod_pkg::OP_BSET;
            end
            if (state_q == bod_pkg::ST_READ) begin
                opnd_q <= mem[ea_q];
            end
            if (state_q == bod_pkg::ST_PROC) begin
                res_q <= alu_res;
                nflags_q <= alu_flags;
                flags_we_q <= alu_flags_we;
            end
        end
    end

    bod_alu u_alu (
        .op_i(op_q),
        .opnd_i(opnd_q),
        .work_i(work_q),
        .bit_i(instr_q[11:9]),
        .res_o(alu_res),
        .flags_o(alu_flags),
        .flags_we_o(alu_flags_we)
    );

    //--------------------------------------------------------------------------
    // Data memory
    //--------------------------------------------------------------------------
    always_comb begin
        mem_we = 1'b0;
        mem_wa = mem_addr_q;
        mem_wd = wr_val[7:0];
        if (state_q == bod_pkg::ST_WRITE && dest_mem_q) begin
            mem_we = 1'b1;
            mem_wa = ea_q;
            mem_wd = res_q;
        end else if (sw_wr && awaddr_q == bod_pkg::MEM_DATA_OFS) begin
            mem_we = 1'b1;
        end
    end

    always_ff @(posedge CLK_I) begin
        if (mem_we) begin
            mem[mem_wa] <= mem_wd;
        end
    end

    //--------------------------------------------------------------------------
    // Assertions
    //--------------------------------------------------------------------------
    always_ff @(posedge CLK_I) begin
        if (!RST_N_I || state_q == bod_pkg::ST_IDLE) begin
            busy_cnt_q <= 3'h0;
        end else begin
            busy_cnt_q <= busy_cnt_q + 3'h1;
        end
    end

    property p_swap;
        @(posedge CLK_I) disable iff (!RST_N_I)
        (state_q == bod_pkg::ST_WRITE && op_q == bod_pkg::OP_SWAP) |-> res_q == {opnd_q[3:0], opnd_q[7:4]};
    endproperty
    a_swap: assert property (p_swap) else $error("swap result wrong");

    property p_dest_w;
        @(posedge CLK_I) disable iff (!RST_N_I)
        (state_q == bod_pkg::ST_WRITE && dest_w_q) |=> work_q == $past(res_q) && !$past(mem_we);
    endproperty
    a_dest_w: assert property (p_dest_w) else $error("work destination not written");

    property p_dest_f;
        @(posedge CLK_I) disable iff (!RST_N_I)
        (state_q == bod_pkg::ST_WRITE && op_q != bod_pkg::OP_NONE && !dest_w_q)
            |-> mem_we && mem_wa == ea_q && mem_wd == res_q;
    endproperty
    a_dest_f: assert property (p_dest_f) else $error("memory destination not written");

    property p_bank;
        @(posedge CLK_I) disable iff (!RST_N_I)
        (state_q == bod_pkg::ST_DECODE && instr_q[8]) |=> ea_q == {bank_q, $past(instr_q[7:0])};
    endproperty
    a_bank: assert property (p_bank) else $error("banked address wrong");

    property p_index;
        @(posedge CLK_I) disable iff (!RST_N_I)
        (state_q == bod_pkg::ST_DECODE && !instr_q[8] && ext_en_q && instr_q[7:0] <= bod_pkg::IDX_LIMIT)
            |=> ea_q == 12'(ptr_q + {4'h0, instr_q[7:0]});
    endproperty
    a_index: assert property (p_index) else $error("indexed address wrong");

    property p_add;
        @(posedge CLK_I) disable iff (!RST_N_I)
        (state_q == bod_pkg::ST_PROC && op_q == bod_pkg::OP_ADD)
            ##1 (state_q == bod_pkg::ST_WRITE) |-> ({nflags_q[bod_pkg::ST_C], res_q} == {1'b0, work_q} + {1'b0, opnd_q})
            ##1 flags_q[bod_pkg::ST_Z] == (res_q == 8'h00);
    endproperty
    a_add: assert property (p_add) else $error("add result or flags wrong");

    property p_fill;
        @(posedge CLK_I) disable iff (!RST_N_I)
        (state_q == bod_pkg::ST_WRITE && op_q == bod_pkg::OP_FILL) |-> mem_wd == 8'hFF && mem_we ##1 $stable(flags_q);
    endproperty
    a_fill: assert property (p_fill) else $error("fill wrong");

    property p_cycle;
        @(posedge CLK_I) disable iff (!RST_N_I)
        (state_q == bod_pkg::ST_IDLE && start) |=> state_q == bod_pkg::ST_DECODE ##1 state_q == bod_pkg::ST_READ
            ##1 state_q == bod_pkg::ST_PROC ##1 state_q == bod_pkg::ST_WRITE ##1 state_q == bod_pkg::ST_IDLE;
    endproperty
    a_cycle: assert property (p_cycle) else $error("instruction cycle sequence wrong");

    property p_cycle_len;
        @(posedge CLK_I) disable iff (!RST_N_I)
        (state_q == bod_pkg::ST_WRITE) |-> busy_cnt_q == 3'(bod_pkg::TCY_CLKS - 1);
    endproperty
    a_cycle_len: assert property (p_cycle_len) else $error("instruction cycle length wrong");

    property p_bset;
        @(posedge CLK_I) disable iff (!RST_N_I)
        (state_q == bod_pkg::ST_WRITE && op_q == bod_pkg::OP_BSET)
            |-> res_q == (opnd_q | (8'h01 << instr_q[11:9])) ##1 $stable(flags_q);
    endproperty
    a_bset: assert property (p_bset) else $error("bit set wrong");
endmodule : bod_core
`default_nettype wire

// >>> test/bod_host.sv
`timescale 1ns/100ps
`default_nettype none
module bod_host (
    input wire logic clk_i,
    output logic [7:0] awaddr_o,
    output logic awvalid_o,
    input wire logic awready_i,
    output logic [31:0] wdata_o,
    output logic wvalid_o,
    input wire logic wready_i,
    input wire logic [1:0] bresp_i,
    input wire logic bvalid_i,
    output logic bready_o,
    output logic [7:0] araddr_o,
    output logic arvalid_o,
    input wire logic arready_i,
    input wire logic [31:0] rdata_i,
    input wire logic [1:0] rresp_i,
    input wire logic rvalid_i,
    output logic rready_o
);
    initial begin
        {awaddr_o, awvalid_o, wdata_o, wvalid_o, bready_o} = '0;
        {araddr_o, arvalid_o, rready_o} = '0;
    end
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        logic aw_pend;
        logic w_pend;
        @(posedge clk_i);
        awaddr_o <= a;
        wdata_o <= d;
        awvalid_o <= 1'b1;
        wvalid_o <= 1'b1;
        bready_o <= 1'b1;
        aw_pend = 1'b1;
        w_pend = 1'b1;
        while (aw_pend || w_pend) begin
            @(posedge clk_i);
            if (aw_pend && awready_i) begin
                awvalid_o <= 1'b0;
                aw_pend = 1'b0;
            end
            if (w_pend && wready_i) begin
                wvalid_o <= 1'b0;
                w_pend = 1'b0;
            end
        end
        do @(posedge clk_i); while (!bvalid_i);
        r = bresp_i;
        bready_o <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge clk_i);
        araddr_o <= a;
        arvalid_o <= 1'b1;
        rready_o <= 1'b1;
        do @(posedge clk_i); while (!arready_i);
        arvalid_o <= 1'b0;
        do @(posedge clk_i); while (!rvalid_i);
        d = rdata_i;
        r = rresp_i;
        rready_o <= 1'b0;
    endtask : rd
endmodule : bod_host
`default_nettype wire

// >>> test/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [1:0] bresp, rresp;
    logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    int n_fail = 0;
    int checked = 0;
    int cycles = 0;
    always #12.5 clk = ~clk;
    bod_core u_bod_core (.CLK_I(clk), .RST_N_I(rst_n), .S_AXI_AWADDR_I(awaddr), .S_AXI_AWVALID_I(awvalid),
        .S_AXI_AWREADY_O(awready), .S_AXI_WDATA_I(wdata), .S_AXI_WSTRB_I(4'hF), .S_AXI_WVALID_I(wvalid),
        .S_AXI_WREADY_O(wready), .S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bvalid), .S_AXI_BREADY_I(bready),
        .S_AXI_ARADDR_I(araddr), .S_AXI_ARVALID_I(arvalid), .S_AXI_ARREADY_O(arready),
        .S_AXI_RDATA_O(rdata), .S_AXI_RRESP_O(rresp), .S_AXI_RVALID_O(rvalid), .S_AXI_RREADY_I(rready));
    bod_host u_bod_host (.clk_i(clk), .awaddr_o(awaddr), .awvalid_o(awvalid), .awready_i(awready),
        .wdata_o(wdata), .wvalid_o(wvalid), .wready_i(wready), .bresp_i(bresp), .bvalid_i(bvalid),
        .bready_o(bready), .araddr_o(araddr), .arvalid_o(arvalid), .arready_i(arready),
        .rdata_i(rdata), .rresp_i(rresp), .rvalid_i(rvalid), .rready_o(rready));
    task automatic report_and_stop;
        if (n_fail == 0 && checked > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : report_and_stop
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            n_fail++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [1:0] r;
        u_bod_host.wr(a, d, r);
        chk("bresp", 32'h0, {30'h0, r});
    endtask : wr
    task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] e);
        logic [31:0] d;
        logic [1:0] r;
        u_bod_host.rd(a, d, r);
        chk("rresp", 32'h0, {30'h0, r});
        chk(nm, e, d);
    endtask : rdchk
    task automatic run(input logic [15:0] ins);
        wr(bod_pkg::INSTR_OFS, {16'h0, ins});
        repeat (4) @(posedge clk);
    endtask : run
    task automatic setmem(input logic [11:0] a, input logic [7:0] d);
        wr(bod_pkg::MEM_ADDR_OFS, {20'h0, a});
        wr(bod_pkg::MEM_DATA_OFS, {24'h0, d});
    endtask : setmem
    task automatic memchk(input logic [11:0] a, input logic [7:0] e);
        wr(bod_pkg::MEM_ADDR_OFS, {20'h0, a});
        rdchk("mem", bod_pkg::MEM_DATA_OFS, {24'h0, e});
    endtask : memchk
    task automatic t_reset;
        logic [31:0] d;
        logic [1:0] r;
        rdchk("work", bod_pkg::WORK_OFS, 32'h0);
        rdchk("status", bod_pkg::STATUS_OFS, 32'h0);
        u_bod_host.rd(8'h40, d, r);
        chk("rresp", 32'h2, {30'h0, r});
        u_bod_host.wr(8'h40, 32'h0, r);
        chk("bresp", 32'h2, {30'h0, r});
    endtask : t_reset
    task automatic t_swap;
        wr(bod_pkg::BANK_OFS, 32'h2);
        setmem(12'h234, 8'h53);
        run({bod_pkg::OPC_SWAP, 1'b1, 1'b1, 8'h34});
        memchk(12'h234, 8'h35);
        run({bod_pkg::OPC_SWAP, 1'b0, 1'b1, 8'h34});
        rdchk("work", bod_pkg::WORK_OFS, 32'h53);
        memchk(12'h234, 8'h35);
        setmem(12'h010, 8'hA5);
        run({bod_pkg::OPC_SWAP, 1'b1, 1'b0, 8'h10});
        memchk(12'h010, 8'h5A);
    endtask : t_swap
    task automatic t_index;
        logic [31:0] d;
        logic [1:0] r;
        wr(bod_pkg::CTRL_OFS, 32'h1);
        wr(bod_pkg::PTR_OFS, 32'hA00);
        setmem(12'hA2C, 8'h88);
        wr(bod_pkg::WORK_OFS, 32'h88);
        wr(bod_pkg::INSTR_OFS, {16'h0, bod_pkg::OPC_ADD, 1'b0, 1'b0, 8'h2C});
        u_bod_host.rd(bod_pkg::STATUS_OFS, d, r);
        chk("busy", 32'h1, {31'h0, d[7]});
        repeat (4) @(posedge clk);
        rdchk("work", bod_pkg::WORK_OFS, 32'h10);
        rdchk("status", bod_pkg::STATUS_OFS, 32'h0B);
        run({bod_pkg::OPC_FILL, 1'b0, 8'h5F});
        memchk(12'hA5F, 8'hFF);
        setmem(12'hF60, 8'h00);
        run({bod_pkg::OPC_FILL, 1'b0, 8'h60});
        memchk(12'hF60, 8'hFF);
        setmem(12'hA0A, 8'h55);
        run({bod_pkg::OPC_BSET, 3'd7, 1'b0, 8'h0A});
        memchk(12'hA0A, 8'hD5);
        rdchk("status", bod_pkg::STATUS_OFS, 32'h0B);
        run(16'hF000);
        rdchk("status", bod_pkg::STATUS_OFS, 32'h4B);
    endtask : t_index
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_fail++;
            report_and_stop();
        end
    end
    initial begin
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        t_reset();
        t_swap();
        t_index();
        report_and_stop();
    end
endmodule : tb
`default_nettype wire
